//--- inc/osdscd_pkg.sv
package osdscd_pkg;
  // command identification codes, upper nibble of the first byte
  localparam logic [3:0] CMD_WADDR = 4'h8;
  localparam logic [3:0] CMD_CHAR = 4'h9;
  localparam logic [3:0] CMD_VPOS = 4'hA;
  localparam logic [3:0] CMD_HPOS = 4'hB;
  localparam logic [3:0] CMD_DC1 = 4'hC;
  localparam logic [3:0] CMD_DC2 = 4'hD;
  localparam logic [3:0] CMD_DC3 = 4'hE;
  localparam logic [3:0] CMD_DC4 = 4'hF;
  // register widths and reset value
  localparam int REG_W = 16;
  localparam logic [15:0] REG_RST = 16'h0000;
  // field positions inside the first byte
  localparam int CHAR_HL_BIT = 1;
  localparam int CHAR_REV_BIT = 0;
  localparam int DC1_RST_BIT = 3;
  localparam int DC1_ERS_BIT = 2;
  localparam int DC1_OSC_BIT = 1;
  localparam int DC1_RND_BIT = 0;
  localparam int DC2_SYNC_BIT = 0;
  // field positions inside the second byte
  localparam int DC1_NI_BIT = 6;
  localparam int DC1_BLK_LSB = 4;
  localparam int DC1_BK_BIT = 3;
  localparam int DC1_ATS_BIT = 2;
  localparam int DC1_DSP_BIT = 0;
  localparam int DC2_TST_BIT = 6;
  localparam int DC2_CHL_BIT = 5;
  localparam int DC2_BKL_BIT = 4;
  localparam int DC2_RSL_LSB = 2;
  localparam int DC2_CVM_BIT = 1;
  localparam int DC2_XTS_BIT = 0;
  // display memory
  localparam int ROWS = 12;
  localparam int COLS = 24;
  localparam int MEM_DEPTH = 512;
  localparam logic [7:0] ERASE_CODE = 8'hFF;
  // erase time budget
  localparam int ERASE_TIME_US = 500;
  localparam int CLK_MHZ = 100;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
endpackage

//--- rtl/osdscd_decoder.sv
`timescale 1ns/100ps
module osdscd_decoder
(
  // system
  input wire logic clk,
  input wire logic arst_n,
  // serial link
  input wire logic serial_clk,
  input wire logic cs_n,
  input wire logic serial_in,
  // display memory write port
  output logic mem_we,
  output logic [8:0] mem_addr,
  output logic [7:0] mem_data,
  output logic mem_reverse,
  output logic mem_highlight,
  output logic erase_busy,
  // size and position
  output logic [1:0] row1_size,
  output logic [1:0] row2_size,
  output logic [1:0] row9_size,
  output logic [1:0] row11_size,
  output logic [5:0] vert_start_pos,
  output logic [5:0] horiz_start_pos,
  // display control one
  output logic glyph_smoothing_en,
  output logic crystal_halt,
  output logic non_interlace,
  output logic [1:0] blanking_size_field,
  output logic flash_period_select,
  output logic attr2_function_select,
  output logic char_output_en,
  // display control two
  output logic [2:0] background_phase_field,
  output logic sync_source_select,
  output logic factory_test_bit,
  output logic char_level_select,
  output logic blank_level_select,
  output logic [1:0] background_level_field,
  output logic video_pedestal_force,
  output logic xtal2_select,
  // display control three and four, raw
  output logic [15:0] display_control_three,
  output logic [15:0] display_control_four
);

  typedef enum logic [1:0] {
    OSDSCD_IDLE = 2'b00,
    OSDSCD_DATA = 2'b01,
    OSDSCD_CHAR = 2'b10
  } osdscd_cmd_e;

  // link domain: shift register, toggle per completed byte
  logic [2:0] bitcnt_q;
  logic [6:0] shift_q;
  logic [7:0] lbyte_q;
  logic ltog_q;

  // bit count cleared as soon as cs rises, no serial clock needed
  always_ff @(posedge serial_clk or negedge arst_n or posedge cs_n)
  begin
    if (!arst_n)
      bitcnt_q <= 3'h0;
    else if (cs_n)
      bitcnt_q <= 3'h0; // partial byte dropped at frame end
    else
      bitcnt_q <= bitcnt_q + 3'h1;
  end

  always_ff @(posedge serial_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_q <= 7'h00;
      lbyte_q <= 8'h00;
      ltog_q <= 1'b0;
    end
    else if (!cs_n)
    begin
      shift_q <= {shift_q[5:0], serial_in};
      if (bitcnt_q == 3'h7)
      begin
        lbyte_q <= {shift_q, serial_in};
        ltog_q <= ~ltog_q;
      end
    end
  end

  // crossings into clk
  logic tog_s1_q, tog_s2_q, tog_s3_q;
  logic cs_s1_q, cs_s2_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
    end
    else
    begin
      tog_s1_q <= ltog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
    end
  end

  logic byte_stb;
  logic cs_high;
  logic [7:0] rx_byte;
  assign byte_stb = tog_s2_q ^ tog_s3_q;
  assign cs_high = cs_s2_q;
  // lbyte_q is stable for a whole byte time after the toggle
  assign rx_byte = lbyte_q;

  // command state
  osdscd_cmd_e state_q;
  logic [3:0] cmd_q;
  logic [3:0] arg_q;
  logic soft_rst_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= OSDSCD_IDLE;
      cmd_q <= osdscd_pkg::CMD_WADDR;
      arg_q <= 4'h0;
    end
    else if (cs_high)
    begin
      state_q <= OSDSCD_IDLE;
      cmd_q <= osdscd_pkg::CMD_WADDR;
    end
    else if (byte_stb)
    begin
      unique case (state_q)
        OSDSCD_CHAR:
        begin
          state_q <= OSDSCD_CHAR;
        end
        OSDSCD_IDLE, OSDSCD_DATA:
        begin
          if (rx_byte[7])
          begin
            cmd_q <= rx_byte[7:4];
            arg_q <= rx_byte[3:0];
            if (rx_byte[7:4] == osdscd_pkg::CMD_CHAR)
              state_q <= OSDSCD_CHAR;
            else
              state_q <= OSDSCD_DATA;
          end
        end
        default:
        begin
          state_q <= OSDSCD_IDLE;
        end
      endcase
    end
  end

  // a data byte for the held command
  logic data_stb;
  logic first_stb;
  assign first_stb = byte_stb && !cs_high && state_q != OSDSCD_CHAR
                     && rx_byte[7];
  assign data_stb = byte_stb && !cs_high && state_q != OSDSCD_CHAR
                    && !rx_byte[7];

  // soft register clear, held until cs goes high
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      soft_rst_q <= 1'b0;
    else if (cs_high)
      soft_rst_q <= 1'b0;
    else if (first_stb && rx_byte[7:4] == osdscd_pkg::CMD_DC1
             && rx_byte[osdscd_pkg::DC1_RST_BIT])
      soft_rst_q <= 1'b1;
  end

  // command registers, {first byte, second byte}
  logic [15:0] reg_q [8];
  logic [7:0] first_byte;
  assign first_byte = {cmd_q, arg_q};

  for (genvar i = 0; i < 8; i++)
  begin : g_reg
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        reg_q[i] <= osdscd_pkg::REG_RST;
      else if (soft_rst_q)
        reg_q[i] <= osdscd_pkg::REG_RST;
      else if (data_stb && cmd_q[2:0] == 3'(i))
        reg_q[i] <= {first_byte, rx_byte};
      else if (i == 4 && first_stb
               && rx_byte[7:4] == osdscd_pkg::CMD_DC1)
        reg_q[i] <= {rx_byte, reg_q[i][7:0]};
      else if (i == 5 && first_stb
               && rx_byte[7:4] == osdscd_pkg::CMD_DC2)
        reg_q[i] <= {rx_byte, reg_q[i][7:0]};
      else if (i == 1 && first_stb
               && rx_byte[7:4] == osdscd_pkg::CMD_CHAR)
        reg_q[i] <= {rx_byte, reg_q[i][7:0]};
    end
  end

  // write address and character writes
  logic [3:0] row_q;
  logic [4:0] col_q;
  logic char_stb;
  assign char_stb = byte_stb && !cs_high && state_q == OSDSCD_CHAR;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      row_q <= 4'h0;
      col_q <= 5'h00;
    end
    else if (soft_rst_q)
    begin
      row_q <= 4'h0;
      col_q <= 5'h00;
    end
    else if (first_stb && rx_byte[7:4] == osdscd_pkg::CMD_WADDR)
      row_q <= rx_byte[3:0];
    else if (data_stb && cmd_q == osdscd_pkg::CMD_WADDR)
      col_q <= rx_byte[4:0];
    else if (char_stb)
    begin
      if (col_q == 5'(osdscd_pkg::COLS - 1))
      begin
        col_q <= 5'h00;
        row_q <= (row_q == 4'(osdscd_pkg::ROWS - 1)) ? 4'h0
                 : row_q + 4'h1;
      end
      else
        col_q <= col_q + 5'h01;
    end
  end

  // erase engine
  logic [16:0] ers_cnt_q;
  logic [8:0] ers_addr_q;
  logic ers_req_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ers_req_q <= 1'b0;
      ers_cnt_q <= 17'h0_0000;
      ers_addr_q <= 9'h000;
    end
    else if (first_stb && rx_byte[7:4] == osdscd_pkg::CMD_DC1
             && rx_byte[osdscd_pkg::DC1_ERS_BIT])
    begin
      ers_req_q <= 1'b1;
      ers_cnt_q <= 17'(osdscd_pkg::ERASE_CYCLES - 1);
      ers_addr_q <= 9'h000;
    end
    else if (ers_req_q && !char_output_en)
    begin
      ers_addr_q <= ers_addr_q
        + {8'h00, ers_addr_q != 9'(osdscd_pkg::MEM_DEPTH - 1)};
      ers_cnt_q <= ers_cnt_q - 17'h0_0001;
      if (ers_cnt_q == 17'h0_0000)
        ers_req_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_we <= 1'b0;
      mem_addr <= 9'h000;
      mem_data <= 8'h00;
      mem_reverse <= 1'b0;
      mem_highlight <= 1'b0;
      erase_busy <= 1'b0;
    end
    else
    begin
      erase_busy <= ers_req_q;
      if (ers_req_q && !char_output_en)
      begin
        mem_we <= ers_addr_q < 9'(osdscd_pkg::MEM_DEPTH - 1);
        mem_addr <= ers_addr_q;
        mem_data <= osdscd_pkg::ERASE_CODE;
        mem_reverse <= 1'b0;
        mem_highlight <= 1'b0;
      end
      else
      begin
        mem_we <= char_stb;
        mem_addr <= {row_q, col_q};
        mem_data <= rx_byte;
        mem_reverse <= reg_q[1][8 + osdscd_pkg::CHAR_REV_BIT];
        mem_highlight <= reg_q[1][8 + osdscd_pkg::CHAR_HL_BIT];
      end
    end
  end

  // decoded control outputs
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      row1_size <= 2'h0;
      row2_size <= 2'h0;
      row9_size <= 2'h0;
      row11_size <= 2'h0;
      vert_start_pos <= 6'h00;
      horiz_start_pos <= 6'h00;
      glyph_smoothing_en <= 1'b0;
      crystal_halt <= 1'b0;
      non_interlace <= 1'b0;
      blanking_size_field <= 2'h0;
      flash_period_select <= 1'b0;
      attr2_function_select <= 1'b0;
      char_output_en <= 1'b0;
      background_phase_field <= 3'h0;
      sync_source_select <= 1'b0;
      factory_test_bit <= 1'b0;
      char_level_select <= 1'b0;
      blank_level_select <= 1'b0;
      background_level_field <= 2'h0;
      video_pedestal_force <= 1'b0;
      xtal2_select <= 1'b0;
      display_control_three <= 16'h0000;
      display_control_four <= 16'h0000;
    end
    else
    begin
      // code 11 reads as normal size
      row1_size <= (&reg_q[2][9:8]) ? 2'h0 : reg_q[2][9:8];
      row2_size <= (&reg_q[2][11:10]) ? 2'h0 : reg_q[2][11:10];
      vert_start_pos <= reg_q[2][5:0];
      row9_size <= (&reg_q[3][9:8]) ? 2'h0 : reg_q[3][9:8];
      row11_size <= (&reg_q[3][11:10]) ? 2'h0 : reg_q[3][11:10];
      horiz_start_pos <= reg_q[3][5:0];
      // size codes one and two are the enlarged ones
      glyph_smoothing_en <= reg_q[4][8 + osdscd_pkg::DC1_RND_BIT]
        && (^reg_q[2][9:8] || ^reg_q[2][11:10]
            || ^reg_q[3][9:8] || ^reg_q[3][11:10]);
      crystal_halt <= reg_q[4][8 + osdscd_pkg::DC1_OSC_BIT]
        && !reg_q[4][osdscd_pkg::DC1_DSP_BIT]
        && !reg_q[5][8 + osdscd_pkg::DC2_SYNC_BIT];
      non_interlace <= reg_q[4][osdscd_pkg::DC1_NI_BIT];
      blanking_size_field <= reg_q[4][osdscd_pkg::DC1_BLK_LSB +: 2];
      flash_period_select <= reg_q[4][osdscd_pkg::DC1_BK_BIT];
      attr2_function_select <= reg_q[4][osdscd_pkg::DC1_ATS_BIT];
      char_output_en <= reg_q[4][osdscd_pkg::DC1_DSP_BIT];
      background_phase_field <= reg_q[5][11:9];
      sync_source_select <= reg_q[5][8 + osdscd_pkg::DC2_SYNC_BIT];
      factory_test_bit <= reg_q[5][osdscd_pkg::DC2_TST_BIT];
      char_level_select <= reg_q[5][osdscd_pkg::DC2_CHL_BIT];
      blank_level_select <= reg_q[5][osdscd_pkg::DC2_BKL_BIT];
      background_level_field <= reg_q[5][osdscd_pkg::DC2_RSL_LSB +: 2];
      video_pedestal_force <= reg_q[5][osdscd_pkg::DC2_CVM_BIT];
      xtal2_select <= reg_q[5][osdscd_pkg::DC2_XTS_BIT];
      display_control_three <= reg_q[6];
      display_control_four <= reg_q[7];
    end
  end

endmodule // osdscd_decoder

//--- verification/osdscd_host.sv
`timescale 1ns/100ps
module osdscd_host
(
  // serial link
  output logic serial_clk,
  output logic cs_n,
  output logic serial_in
);
  initial
  begin
    serial_clk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b1;
  end

  // lone edge while deselected, lets reset reach the link side
  task automatic tick();
    #40 serial_clk = 1'b1;
    #40 serial_clk = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      serial_in = b[i];
      #20 serial_clk = 1'b1;
      #40 serial_clk = 1'b0;
      #20;
    end
    // hold time over, line no longer shows the last bit
    serial_in = ~b[0];
    #640;
  endtask

  task automatic frame(input logic [7:0] q[$]);
    #7 cs_n = 1'b0;
    #200;
    foreach (q[i])
      send_byte(q[i]);
    #100 cs_n = 1'b1;
    serial_in = 1'b1;
    #1000;
  endtask
endmodule // osdscd_host

//--- verification/osdscd_decoder_assertions.sv
`timescale 1ns/100ps
module osdscd_decoder_chk
(
  // system
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cs_n,
  // memory port
  input wire logic mem_we,
  input wire logic [8:0] mem_addr,
  input wire logic [7:0] mem_data,
  input wire logic erase_busy,
  // fields
  input wire logic [1:0] row1_size,
  input wire logic [1:0] row2_size,
  input wire logic [1:0] row9_size,
  input wire logic [1:0] row11_size,
  input wire logic [5:0] vert_start_pos,
  input wire logic [5:0] horiz_start_pos,
  input wire logic glyph_smoothing_en,
  input wire logic crystal_halt,
  input wire logic char_output_en,
  input wire logic sync_source_select
);
  logic [3:0] idle_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      idle_q <= 4'h0;
    else if (cs_n)
      idle_q <= idle_q + {3'h0, idle_q != 4'hf};
    else
      idle_q <= 4'h0;
  end

  a_reset_clear: assert property (@(posedge clk)
    !arst_n |-> !mem_we && vert_start_pos == 6'h00 && row1_size == 2'h0
    && !char_output_en && horiz_start_pos == 6'h00)
    else $error("outputs not cleared in reset");
  a_we_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    mem_we && !erase_busy |=> !mem_we)
    else $error("character write pulse too long");
  a_erase_fill: assert property (@(posedge clk) disable iff (!arst_n)
    mem_we && erase_busy |-> mem_data == 8'hff)
    else $error("erase wrote other than ff");
  a_erase_dark: assert property (@(posedge clk) disable iff (!arst_n)
    mem_we && erase_busy |-> !char_output_en)
    else $error("erase with display on");
  a_idle_stable: assert property (@(posedge clk) disable iff (!arst_n)
    idle_q == 4'hf |-> $stable(vert_start_pos) && $stable(horiz_start_pos)
    && $stable(row1_size) && $stable(row11_size))
    else $error("field changed while deselected");
  a_vsize_legal: assert property (@(posedge clk) disable iff (!arst_n)
    row1_size != 2'h3 && row2_size != 2'h3)
    else $error("row one or two size code three");
  a_hsize_legal: assert property (@(posedge clk) disable iff (!arst_n)
    row9_size != 2'h3 && row11_size != 2'h3)
    else $error("row nine or eleven size code three");
  a_halt_gate: assert property (@(posedge clk) disable iff (!arst_n)
    crystal_halt |-> !char_output_en && !sync_source_select)
    else $error("crystal halted in wrong mode");
  a_smooth_gate: assert property (@(posedge clk) disable iff (!arst_n)
    glyph_smoothing_en |-> |{row1_size, row2_size, row9_size, row11_size})
    else $error("smoothing with all normal sizes");
  a_col_range: assert property (@(posedge clk) disable iff (!arst_n)
    mem_we && !erase_busy |-> mem_addr[4:0] <= 5'h17)
    else $error("column beyond last");
endmodule // osdscd_decoder_chk

bind osdscd_decoder osdscd_decoder_chk chk
(
  .clk, .arst_n, .cs_n, .mem_we, .mem_addr, .mem_data, .erase_busy,
  .row1_size, .row2_size, .row9_size, .row11_size, .vert_start_pos,
  .horiz_start_pos, .glyph_smoothing_en, .crystal_halt, .char_output_en,
  .sync_source_select
);

//--- verification/osd_serial_command_decoder_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
    end \
  end
module osd_serial_command_decoder_tb;
  logic clk, arst_n, serial_clk, cs_n, serial_in;
  logic mem_we, mem_reverse, mem_highlight, erase_busy;
  logic [8:0] mem_addr;
  logic [7:0] mem_data;
  logic [1:0] row1_size, row2_size, row9_size, row11_size;
  logic [5:0] vert_start_pos, horiz_start_pos;
  logic glyph_smoothing_en, crystal_halt, non_interlace, flash_period_select;
  logic attr2_function_select, char_output_en, sync_source_select;
  logic factory_test_bit, char_level_select, blank_level_select;
  logic video_pedestal_force, xtal2_select;
  logic [1:0] blanking_size_field, background_level_field;
  logic [2:0] background_phase_field;
  logic [15:0] display_control_three, display_control_four;
  int fail_count, compares, erase_n, c;
  logic [31:0] seed, t;
  logic [3:0] rr;
  logic [7:0] q[$];
  logic [18:0] exp_q[$];
  logic [18:0] got_e;
  logic [7:0] va, vb, ha, hb, d1a, d1b, d2a, d2b, d3a, d3b, d4a, d4b;

  osdscd_decoder uut
  (
    .clk, .arst_n, .serial_clk, .cs_n, .serial_in, .mem_we, .mem_addr,
    .mem_data, .mem_reverse, .mem_highlight, .erase_busy, .row1_size,
    .row2_size, .row9_size, .row11_size, .vert_start_pos, .horiz_start_pos,
    .glyph_smoothing_en, .crystal_halt, .non_interlace, .blanking_size_field,
    .flash_period_select, .attr2_function_select, .char_output_en,
    .background_phase_field, .sync_source_select, .factory_test_bit,
    .char_level_select, .blank_level_select, .background_level_field,
    .video_pedestal_force, .xtal2_select, .display_control_three,
    .display_control_four
  );

  osdscd_host host
  (
    .serial_clk, .cs_n, .serial_in
  );

  always #5 clk = ~clk;

  // memory write monitor
  always @(negedge clk)
  begin
    if (arst_n && mem_we === 1'b1)
    begin
      if (erase_busy === 1'b1)
      begin
        erase_n++;
        `CHK("erase data", 8'hff, mem_data)
      end
      else
      begin
        got_e = (exp_q.size() > 0) ? exp_q.pop_front() : 19'h7_ffff;
        `CHK("char write", got_e, {mem_addr, mem_data, mem_highlight, mem_reverse})
      end
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [1:0] sz(input logic [1:0] code);
    return (code == 2'h3) ? 2'h0 : code;
  endfunction

  task automatic send();
    host.frame(q);
    q.delete();
    @(negedge clk);
  endtask

  task automatic clr();
    {va, vb, ha, hb, d1a, d1b, d2a, d2b, d3a, d3b, d4a, d4b} = '0;
  endtask

  task automatic check_fields();
    logic big;
    big = |{sz(va[3:2]), sz(va[1:0]), sz(ha[3:2]), sz(ha[1:0])};
    `CHK("row1", sz(va[1:0]), row1_size)
    `CHK("row2", sz(va[3:2]), row2_size)
    `CHK("row9", sz(ha[1:0]), row9_size)
    `CHK("row11", sz(ha[3:2]), row11_size)
    `CHK("vpos", vb[5:0], vert_start_pos)
    `CHK("hpos", hb[5:0], horiz_start_pos)
    `CHK("smooth", d1a[0] & big, glyph_smoothing_en)
    `CHK("halt", d1a[1] & ~d1b[0] & ~d2a[0], crystal_halt)
    `CHK("interlace", d1b[6], non_interlace)
    `CHK("blank_size", d1b[5:4], blanking_size_field)
    `CHK("flash_period", d1b[3], flash_period_select)
    `CHK("attr2fn", d1b[2], attr2_function_select)
    `CHK("output_en", d1b[0], char_output_en)
    `CHK("phase", d2a[3:1], background_phase_field)
    `CHK("sync_src", d2a[0], sync_source_select)
    `CHK("test_bit", d2b[6], factory_test_bit)
    `CHK("char_level", d2b[5], char_level_select)
    `CHK("blank_level", d2b[4], blank_level_select)
    `CHK("bg_level", d2b[3:2], background_level_field)
    `CHK("pedestal", d2b[1], video_pedestal_force)
    `CHK("xtal2", d2b[0], xtal2_select)
    `CHK("dc3", {d3a, d3b}, display_control_three)
    `CHK("dc4", {d4a, d4b}, display_control_four)
  endtask

  // each command from VPOS to DC4 once, last data byte of a command wins
  task automatic rand_cfg(input bit halt);
    t = xs();
    va = {4'ha, t[3:0]};
    vb = {2'h0, t[9:5], 1'b1};
    ha = {4'hb, t[13:10]};
    hb = {2'h0, t[19:14]};
    d1a = {6'h30, t[21:20]};
    d1b = {1'b0, t[26:22], 1'b0, t[27] & ~halt};
    d1a[1] = d1a[1] | halt;
    t = xs();
    d2a = {4'hd, t[3:1], t[0] & ~halt};
    d2b = {2'h0, t[9:4]};
    d3a = {4'he, t[13:10]};
    d3b = {1'b0, t[20:14]};
    d4a = {4'hf, t[24:21]};
    d4b = {1'b0, t[31:25]};
    q = '{va, 8'(xs() & 32'h3f), vb, ha, hb, d1a, d1b, d2a, d2b, d3a, d3b,
      d4a, d4b};
    send();
    check_fields();
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #950_000;
    fail_count++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    seed = 32'heef9_421e;
    fail_count = 0;
    compares = 0;
    erase_n = 0;
    clr();
    host.tick();
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) @(negedge clk);
    check_fields();
    $display("test reset done");
    for (int a = 0; a < 4; a++)
    begin
      rr = 4'(xs() % 11);
      t = xs();
      q = '{{4'h8, rr}, 8'h16, 8'(8'h90 | a), {1'b0, t[6:0]}, 8'h7f, 8'hfe,
        8'hff};
      for (int k = 0; k < 4; k++)
      begin
        c = 22 + k;
        exp_q.push_back({4'(rr + c / 24), 5'(c % 24), q[k + 3], 2'(a)});
      end
      send();
      `CHK("writes left", 0, exp_q.size())
    end
    $display("test character write done");
    q = '{8'h83, 8'h00};
    send();
    q = '{8'h07, 8'h90, 8'h41};
    exp_q.push_back({4'h3, 5'h07, 8'h41, 2'h0});
    send();
    `CHK("bare column", 0, exp_q.size())
    $display("test bare data byte done");
    for (int i = 0; i < 7; i++)
      rand_cfg(i == 0);
    $display("test command fields done");
    q = '{8'hc8, 8'h00};
    fork
      send();
      begin
        #2500;
        `CHK("soft clear", 6'h00, vert_start_pos)
      end
    join
    clr();
    check_fields();
    $display("test soft clear done");
    q = '{8'hc4, 8'h00};
    d1a = 8'hc4;
    send();
    for (int i = 0; i < 60000 && (erase_n < 511 || erase_busy !== 1'b0); i++)
      @(negedge clk);
    `CHK("erase count", 511, erase_n)
    `CHK("erase end", 1'b0, erase_busy)
    check_fields();
    $display("test erase done");
    rand_cfg(1'b0);
    @(posedge clk);
    #1 arst_n = 1'b0;
    host.tick();
    repeat (12) @(posedge clk);
    clr();
    check_fields();
    `CHK("we in reset", 1'b0, mem_we)
    #1 arst_n = 1'b1;
    $display("test hard reset done");
    report_and_stop();
  end
endmodule // osd_serial_command_decoder_tb
